/* File: fio_core.sv */
// execution of byte file operations and pointer-indirect loads into the operand register
//
// Behaviour
// - file address 0..127; target bit 0 writes operand register, 1 writes file location.
// - increment adds one to the byte, writes target, updates zero flag.
// - or combines operand register with byte, writes target, updates zero flag.
// - left shift: bit 7 to carry, bits 6:0 up, zero into bit 0.
// - right shift: zero into bit 7, bits 7:1 down, bit 0 to carry.
// - copy moves byte unchanged to target and updates zero flag.
// - indirect load reads location at pointer into operand register, updates zero flag.
// - step select 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - pre modes access and keep new pointer; post modes access old then step.
// - relative form accesses pointer plus signed offset -32..31; pointer unchanged.
// - pointers are 16 bits and wrap modulo 65536.
// - pointer stepping never alters status flags.
`timescale 1ns/1ps
`default_nettype none
`include "fio_defines.svh"

module fio_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire fio_pkg::fio_op_e op_code,
  input wire logic [6:0] file_addr,
  input wire logic dest_sel,
  input wire logic ptr_sel,
  input wire logic [1:0] pointer_step_sel,
  input wire logic rel_mode,
  input wire logic [5:0] rel_offset,
  input wire logic w_load_en,
  input wire logic [7:0] w_load_data,
  input wire logic ptr_load_en,
  input wire logic ptr_load_sel,
  input wire logic [15:0] ptr_load_data,
  input wire logic mem_load_en,
  input wire logic [6:0] mem_load_addr,
  input wire logic [7:0] mem_load_data,
  output logic [7:0] w_out,
  output logic zero_out,
  output logic carry_out,
  output logic [15:0] pointer_reg0_out,
  output logic [15:0] pointer_reg1_out,
  output logic wb_valid,
  output logic [6:0] wb_addr,
  output logic [7:0] wb_data,
  output logic [15:0] eff_addr_out,
  output logic done
);

  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == `FIO_RST_BYTE);
  endfunction

  // 16-bit add/subtract of one; the cut to 16 bits is the wrap
  function automatic logic [15:0] ptr_step(input logic [15:0] ptr, input logic down);
    ptr_step = down ? 16'(ptr - `FIO_ONE_PTR) : 16'(ptr + `FIO_ONE_PTR);
  endfunction

  // the data memory holds only 128 bytes, so indirect addresses alias onto it by their low bits
  function automatic logic [6:0] mem_index(input logic [15:0] addr);
    mem_index = addr[6:0];
  endfunction

  fio_pkg::fio_state_s state_reg;
  fio_pkg::fio_state_s state_next;
  logic [7:0] data_mem [`FIO_MEM_DEPTH];

  logic [15:0] ptr_cur;
  logic [15:0] ptr_stepped;
  logic [15:0] ptr_after;
  logic [15:0] ind_addr;
  logic [7:0] operand;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_updates_carry;
  logic is_file_op;
  logic is_indirect;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;

  // anything but the no-op and the indirect load is a byte operation on the addressed location
  always_comb begin
    is_file_op = 1'b0;
    is_indirect = 1'b0;
    if (op_valid) begin
      unique case (op_code)
        fio_pkg::FIO_OP_NONE: begin
          is_file_op = 1'b0;
        end
        fio_pkg::FIO_OP_INDIRECT_LOAD: begin
          is_indirect = 1'b1;
        end
        default: begin
          is_file_op = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    ptr_cur = ptr_sel ? state_reg.ptr1 : state_reg.ptr0;
    // bit 0 of the step select picks the direction, bit 1 picks post over pre
    ptr_stepped = ptr_step(ptr_cur, pointer_step_sel[0]);
    if (rel_mode) begin
      ind_addr = 16'(ptr_cur + {{10{rel_offset[5]}}, rel_offset});
      ptr_after = ptr_cur;
    end else begin
      unique case (pointer_step_sel)
        `FIO_STEP_PRE_INC, `FIO_STEP_PRE_DEC: begin
          ind_addr = ptr_stepped;
        end
        default: begin
          ind_addr = ptr_cur;
        end
      endcase
      ptr_after = ptr_stepped;
    end
  end

  // the indirect window is just an address path into the data memory, no storage of its own
  always_comb begin
    if (is_indirect) begin
      operand = data_mem[mem_index(ind_addr)];
    end else begin
      operand = data_mem[file_addr];
    end
  end

  fio_alu fio_alu_i (
    .op(op_code),
    .operand(operand),
    .w_value(state_reg.w),
    .carry_in(state_reg.carry),
    .result(alu_result),
    .carry_out(alu_carry),
    .updates_carry(alu_updates_carry)
  );

  always_comb begin
    state_next = state_reg;
    state_next.wb_valid = 1'b0;
    state_next.done = 1'b0;
    mem_we = 1'b0;
    mem_waddr = mem_load_addr;
    mem_wdata = mem_load_data;
    if (w_load_en) begin
      state_next.w = w_load_data;
    end
    if (ptr_load_en && !ptr_load_sel) begin
      state_next.ptr0 = ptr_load_data;
    end
    if (ptr_load_en && ptr_load_sel) begin
      state_next.ptr1 = ptr_load_data;
    end
    if (mem_load_en) begin
      mem_we = 1'b1;
    end
    // an operation outranks the side-loads in the same cycle
    if (is_file_op) begin
      state_next.zero = is_zero(alu_result);
      if (alu_updates_carry) begin
        state_next.carry = alu_carry;
      end
      if (dest_sel == `FIO_DEST_FILE) begin
        mem_we = 1'b1;
        mem_waddr = file_addr;
        mem_wdata = alu_result;
        state_next.wb_valid = 1'b1;
        state_next.wb_addr = file_addr;
        state_next.wb_data = alu_result;
      end else begin
        state_next.w = alu_result;
      end
      state_next.done = 1'b1;
    end else if (is_indirect) begin
      state_next.w = operand;
      // flags follow only the byte moved, the pointer step leaves them alone
      state_next.zero = is_zero(operand);
      if (ptr_sel) begin
        state_next.ptr1 = ptr_after;
      end else begin
        state_next.ptr0 = ptr_after;
      end
      state_next.eff_addr = ind_addr;
      state_next.done = 1'b1;
    end
  end

  // one register holds all state except the data memory; the outputs below are plain copies of its fields
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // memory contents are not reset; software preloads them through the load port
  always_ff @(posedge clock) begin
    if (mem_we) begin
      data_mem[mem_waddr] <= mem_wdata;
    end
  end

  assign w_out = state_reg.w;
  assign zero_out = state_reg.zero;
  assign carry_out = state_reg.carry;
  assign pointer_reg0_out = state_reg.ptr0;
  assign pointer_reg1_out = state_reg.ptr1;
  assign wb_valid = state_reg.wb_valid;
  assign wb_addr = state_reg.wb_addr;
  assign wb_data = state_reg.wb_data;
  assign eff_addr_out = state_reg.eff_addr;
  assign done = state_reg.done;

endmodule

`default_nettype wire

/* File: fio_defines.svh */
// constants for the file-operation and indirect-load execution block
`ifndef FIO_DEFINES_SVH
`define FIO_DEFINES_SVH

`define FIO_DATA_W 8
`define FIO_FADDR_W 7
`define FIO_PTR_W 16
`define FIO_OFS_W 6
`define FIO_MEM_DEPTH 128
`define FIO_FADDR_MAX 7'h7f
`define FIO_OFS_MIN 6'h20
`define FIO_OFS_MAX 6'h1f
`define FIO_DEST_W 1'b0
`define FIO_DEST_FILE 1'b1
`define FIO_STEP_PRE_INC 2'h0
`define FIO_STEP_PRE_DEC 2'h1
`define FIO_STEP_POST_INC 2'h2
`define FIO_STEP_POST_DEC 2'h3
`define FIO_RST_BYTE 8'h00
`define FIO_RST_PTR 16'h0000
`define FIO_ONE_BYTE 8'h01
`define FIO_ONE_PTR 16'h0001

`endif

/* File: fio_pkg.sv */
// types shared by the file-operation execution block
package fio_pkg;

  typedef enum logic [2:0] {
    FIO_OP_NONE,
    FIO_OP_INCREMENT,
    FIO_OP_OR_INTO,
    FIO_OP_SHIFT_LEFT,
    FIO_OP_SHIFT_RIGHT,
    FIO_OP_COPY,
    FIO_OP_INDIRECT_LOAD
  } fio_op_e;

  typedef struct packed {
    logic [7:0] w;
    logic zero;
    logic carry;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic wb_valid;
    logic [6:0] wb_addr;
    logic [7:0] wb_data;
    logic [15:0] eff_addr;
    logic done;
  } fio_state_s;

endpackage

/* File: fio_alu.sv */
// byte operation unit: increment, or, shifts with the outgoing bit to carry and zero shifted in, copy
`timescale 1ns/1ps
`default_nettype none
`include "fio_defines.svh"

module fio_alu (
  input wire fio_pkg::fio_op_e op,
  input wire logic [7:0] operand,
  input wire logic [7:0] w_value,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic updates_carry
);

  always_comb begin
    result = operand;
    carry_out = carry_in;
    updates_carry = 1'b0;
    unique case (op)
      fio_pkg::FIO_OP_INCREMENT: begin
        // wraps ff to 00, which the zero flag then reports
        result = 8'(operand + `FIO_ONE_BYTE);
      end
      fio_pkg::FIO_OP_OR_INTO: begin
        result = w_value | operand;
      end
      fio_pkg::FIO_OP_SHIFT_LEFT: begin
        result = {operand[6:0], 1'b0};
        carry_out = operand[7];
        updates_carry = 1'b1;
      end
      fio_pkg::FIO_OP_SHIFT_RIGHT: begin
        result = {1'b0, operand[7:1]};
        carry_out = operand[0];
        updates_carry = 1'b1;
      end
      fio_pkg::FIO_OP_COPY, fio_pkg::FIO_OP_INDIRECT_LOAD: begin
        result = operand;
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule

`default_nettype wire

/* File: fio_core_chk.sv */
// concurrent checks on the ports of fio_core
`timescale 1ns/1ps
`default_nettype none
module fio_core_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire fio_pkg::fio_op_e op_code,
  input wire logic [6:0] file_addr,
  input wire logic dest_sel,
  input wire logic ptr_sel,
  input wire logic [1:0] pointer_step_sel,
  input wire logic rel_mode,
  input wire logic [7:0] w_out,
  input wire logic zero_out,
  input wire logic carry_out,
  input wire logic [15:0] pointer_reg0_out,
  input wire logic wb_valid,
  input wire logic [6:0] wb_addr,
  input wire logic [7:0] wb_data,
  input wire logic [15:0] eff_addr_out,
  input wire logic done
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic go, bop;
  logic [7:0] res;
  assign go = op_valid && op_code != fio_pkg::FIO_OP_NONE;
  assign bop = go && op_code != fio_pkg::FIO_OP_INDIRECT_LOAD;
  // result byte wherever it landed, so one check covers both targets
  assign res = wb_valid ? wb_data : w_out;
  sequence ld_s;
    go && op_code == fio_pkg::FIO_OP_INDIRECT_LOAD && !ptr_sel;
  endsequence
  done_latency_a: assert property (go |=> done) else $error("done late");
  file_target_a: assert property (bop && dest_sel |=> wb_valid && wb_addr == $past(file_addr))
    else $error("no write-back");
  zero_flag_a: assert property (done |-> zero_out == (res == 8'h00)) else $error("zero flag");
  or_keeps_a: assert property (go && op_code == fio_pkg::FIO_OP_OR_INTO && !dest_sel |=>
    (w_out | $past(w_out)) == w_out) else $error("or lost bits");
  shl_lsb_a: assert property (go && op_code == fio_pkg::FIO_OP_SHIFT_LEFT |=> !res[0]) else $error("shl lsb");
  shr_msb_a: assert property (go && op_code == fio_pkg::FIO_OP_SHIFT_RIGHT |=> !res[7]) else $error("shr msb");
  rel_hold_a: assert property (ld_s ##0 rel_mode |=> $stable(pointer_reg0_out)) else $error("pointer moved");
  post_addr_a: assert property (ld_s ##0 !rel_mode && pointer_step_sel[1] |=>
    eff_addr_out == $past(pointer_reg0_out)) else $error("post address");
  pre_addr_a: assert property (ld_s ##0 !rel_mode && !pointer_step_sel[1] |=>
    eff_addr_out == pointer_reg0_out) else $error("pre address");
  ind_carry_a: assert property (go && op_code == fio_pkg::FIO_OP_INDIRECT_LOAD |=> $stable(carry_out))
    else $error("carry moved");
endmodule
bind fio_core fio_core_chk fio_core_chk_i (
  .clock(clock),
  .rst_b(rst_b),
  .op_valid(op_valid),
  .op_code(op_code),
  .file_addr(file_addr),
  .dest_sel(dest_sel),
  .ptr_sel(ptr_sel),
  .pointer_step_sel(pointer_step_sel),
  .rel_mode(rel_mode),
  .w_out(w_out),
  .zero_out(zero_out),
  .carry_out(carry_out),
  .pointer_reg0_out(pointer_reg0_out),
  .wb_valid(wb_valid),
  .wb_addr(wb_addr),
  .wb_data(wb_data),
  .eff_addr_out(eff_addr_out),
  .done(done)
);
`default_nettype wire

/* File: fio_core_tb.sv */
// self-checking testbench for fio_core
`timescale 1ns/1ps
`default_nettype none
module fio_core_tb;
  logic clock, rst_b, op_valid, dest_sel, ptr_sel, rel_mode, zero_out, carry_out, wb_valid, done;
  logic w_load_en, ptr_load_en, ptr_load_sel, mem_load_en;
  fio_pkg::fio_op_e op_code;
  logic [1:0] pointer_step_sel;
  logic [5:0] rel_offset;
  logic [6:0] file_addr, mem_load_addr, wb_addr;
  logic [7:0] w_load_data, mem_load_data, w_out, wb_data;
  logic [15:0] ptr_load_data, pointer_reg0_out, pointer_reg1_out, eff_addr_out, p, q, e;
  int failures, checks_done;
  fio_core fio_core_i (
    .clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .file_addr(file_addr),
    .dest_sel(dest_sel), .ptr_sel(ptr_sel), .pointer_step_sel(pointer_step_sel), .rel_mode(rel_mode),
    .rel_offset(rel_offset), .w_load_en(w_load_en), .w_load_data(w_load_data), .ptr_load_en(ptr_load_en),
    .ptr_load_sel(ptr_load_sel), .ptr_load_data(ptr_load_data), .mem_load_en(mem_load_en),
    .mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data), .w_out(w_out), .zero_out(zero_out),
    .carry_out(carry_out), .pointer_reg0_out(pointer_reg0_out), .pointer_reg1_out(pointer_reg1_out),
    .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data), .eff_addr_out(eff_addr_out), .done(done)
  );
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // op_valid stays high on return so ops can run back to back
  task automatic run(input fio_pkg::fio_op_e o, input logic [6:0] a, input logic d, input logic [1:0] m,
                     input logic r, input logic [5:0] k);
    op_valid = 1'b1;
    op_code = o;
    file_addr = a;
    dest_sel = d;
    pointer_step_sel = m;
    rel_mode = r;
    rel_offset = k;
    @(negedge clock);
    cmp(done, 1'b1);
  endtask
  task automatic bop(input fio_pkg::fio_op_e o, input logic [6:0] a, input logic d, input logic [7:0] v,
                     input logic c);
    run(o, a, d, 2'h0, 1'b0, 6'h00);
    cmp(d ? wb_data : w_out, v);
    cmp(wb_valid, d);
    cmp(zero_out, v == 8'h00);
    cmp(carry_out, c);
    if (d) cmp(wb_addr, a);
  endtask
  task automatic tally_and_finish;
    $display("%0d checks, %0d failures", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rst_b, op_valid, dest_sel, ptr_sel, rel_mode, w_load_en, ptr_load_en, ptr_load_sel, mem_load_en} = '0;
    {file_addr, mem_load_addr, pointer_step_sel, rel_offset, w_load_data, mem_load_data, ptr_load_data} = '0;
    op_code = fio_pkg::FIO_OP_NONE;
    failures = 0;
    checks_done = 0;
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    cmp(pointer_reg0_out, 16'h0000);
    // memory is not reset: each byte holds its own address
    mem_load_en = 1'b1;
    for (int i = 0; i < 128; i++) begin
      mem_load_addr = i[6:0];
      mem_load_data = i[7:0];
      @(negedge clock);
    end
    mem_load_en = 1'b0;
    bop(fio_pkg::FIO_OP_SHIFT_RIGHT, 7'h01, 1'b0, 8'h00, 1'b1);
    op_valid = 1'b0;
    ptr_load_en = 1'b1;
    ptr_load_data = 16'hffff;
    @(negedge clock);
    ptr_load_en = 1'b0;
    for (int m = 0; m < 4; m++) begin
      p = pointer_reg0_out;
      q = m[0] ? p - 16'h0001 : p + 16'h0001;
      e = m[1] ? p : q;
      run(fio_pkg::FIO_OP_INDIRECT_LOAD, 7'h00, 1'b0, m[1:0], 1'b0, 6'h00);
      cmp(eff_addr_out, e);
      cmp(pointer_reg0_out, q);
      cmp(w_out, {9'h000, e[6:0]});
      cmp(zero_out, e[6:0] == 7'h00);
      cmp(carry_out, 1'b1);
    end
    op_valid = 1'b0;
    ptr_load_en = 1'b1;
    ptr_load_data = 16'h0010;
    @(negedge clock);
    ptr_load_en = 1'b0;
    run(fio_pkg::FIO_OP_INDIRECT_LOAD, 7'h00, 1'b0, 2'h2, 1'b1, 6'h20);
    cmp(eff_addr_out, 16'hfff0);
    cmp(pointer_reg0_out, 16'h0010);
    cmp(w_out, 16'h0070);
    bop(fio_pkg::FIO_OP_INCREMENT, 7'h7f, 1'b1, 8'h80, 1'b1);
    bop(fio_pkg::FIO_OP_OR_INTO, 7'h0f, 1'b0, 8'h7f, 1'b1);
    bop(fio_pkg::FIO_OP_SHIFT_LEFT, 7'h41, 1'b1, 8'h82, 1'b0);
    bop(fio_pkg::FIO_OP_SHIFT_LEFT, 7'h41, 1'b0, 8'h04, 1'b1);
    bop(fio_pkg::FIO_OP_COPY, 7'h00, 1'b1, 8'h00, 1'b1);
    // no-op with side-loads of w and pointer 1: nothing executes, both loads land
    op_code = fio_pkg::FIO_OP_NONE;
    ptr_load_en = 1'b1;
    ptr_load_sel = 1'b1;
    ptr_load_data = 16'h0005;
    w_load_en = 1'b1;
    w_load_data = 8'h80;
    @(negedge clock);
    ptr_load_en = 1'b0;
    w_load_en = 1'b0;
    cmp(done, 1'b0);
    cmp(w_out, 16'h0080);
    cmp(pointer_reg1_out, 16'h0005);
    ptr_sel = 1'b1;
    bop(fio_pkg::FIO_OP_OR_INTO, 7'h05, 1'b1, 8'h85, 1'b1);
    run(fio_pkg::FIO_OP_INDIRECT_LOAD, 7'h00, 1'b0, 2'h2, 1'b0, 6'h00);
    cmp(eff_addr_out, 16'h0005);
    cmp(pointer_reg1_out, 16'h0006);
    cmp(pointer_reg0_out, 16'h0010);
    cmp(w_out, 16'h0085);
    run(fio_pkg::FIO_OP_INDIRECT_LOAD, 7'h00, 1'b0, 2'h0, 1'b1, 6'h1f);
    cmp(eff_addr_out, 16'h0025);
    cmp(pointer_reg1_out, 16'h0006);
    cmp(w_out, 16'h0025);
    cmp(zero_out, 1'b0);
    cmp(carry_out, 1'b1);
    ptr_sel = 1'b0;
    tally_and_finish;
  end
endmodule
`default_nettype wire
